/* logic/mme_monitor_entry.sv */
// Summary of operation
// - blank reset vector bytes allow monitor entry without test high voltage.
// - high-voltage entry: bus clock input divided by two or four.
// - divide-select low with high voltage bypasses oscillator halving stage.
// - blank-vector entry ignores port A conditions and divide-select pin.
// - blank-vector entry always divides external clock by four.
// - blank entry at 4.9152 MHz gives 1.2288 MHz bus, 4800 baud.
// - blank-vector session runs one extra reset cycle after each reset pin release.
// - blank-vector session keeps watchdog disabled regardless of pins.
// - high-voltage session disables watchdog only while voltage remains.
// - mode latched on reset pin rising edge, then pins are free.
// - after reset, wait for eight security bytes from the host.
// - then send a break of ten zero bits to signal ready.
// - single wired-OR serial pin, each side only pulls low.
// - serial traffic uses standard NRZ mark/space characters.
// - monitor mode takes reset, interrupt vectors from the monitor page.
// - baud divide 1024 when divide-select high, 512 low, blank 1024.
// - blank-vector monitor mode left only by power-on reset.
`timescale 1ns/1ns
`default_nettype none
module mme_monitor_entry
(
   input  wire logic                     ref_clk_in,
   input  wire logic                     resetn_in,
   input  wire logic                     reset_pin_in,
   input  wire logic                     external_interrupt_pin_in,
   input  wire logic                     test_hv_irq_in,
   input  wire logic                     test_hv_rst_in,
   input  wire logic                     clock_divide_select_pin_in,
   input  wire logic [7:0]               vector_high_byte_in,
   input  wire logic [7:0]               vector_low_byte_in,
   input  wire logic                     serial_comm_pin_in,
   output logic                          serial_comm_pin_out,
   output logic                          serial_comm_pin_oe_out,
   output logic                          monitor_mode_out,
   output logic                          blank_entry_out,
   output logic                          bus_div4_out,
   output logic                          osc_bypass_out,
   output logic                          baud_div_1024_out,
   output logic                          watchdog_disable_out,
   output logic [7:0]                    vector_page_out,
   output logic                          core_reset_out,
   output logic                          ready_out
);
   import mme_pkg::*;

   logic [PIN_W-1:0] sync1_ff;
   logic [PIN_W-1:0] sync2_ff;
   logic [PIN_W-1:0] sync3_ff;
   logic [PIN_W-1:0] pin_ff;
   logic [PIN_W-1:0] pin_raw;
   logic             rst_prev_ff;
   logic             rst_rise;
   logic             vec_blank;
   logic             monitor_ff;
   logic             blank_ff;
   logic             div_hi_ff;
   mme_state_t       state_ff;
   logic [5:0]       extra_cnt_ff;
   logic [10:0]      bit_len;
   logic [10:0]      baud_cnt_ff;
   logic [3:0]       bit_cnt_ff;
   logic [3:0]       sec_cnt_ff;
   logic             rx_busy_ff;
   logic             oe_ff;
   logic             brk_done_ff;
   logic [13:0]      brk_len_ff;

   assign pin_raw = {serial_comm_pin_in, clock_divide_select_pin_in,
                     test_hv_rst_in, test_hv_irq_in,
                     external_interrupt_pin_in, reset_pin_in};

   // three-stage synchronisers; a level counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk_in)
         begin
            if (!resetn_in)
            begin
               sync1_ff[gi] <= PIN_RESET_VAL[gi];
               sync2_ff[gi] <= PIN_RESET_VAL[gi];
               sync3_ff[gi] <= PIN_RESET_VAL[gi];
               pin_ff[gi]   <= PIN_RESET_VAL[gi];
            end
            else
            begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi])
               begin
                  pin_ff[gi] <= sync3_ff[gi];
               end
            end
         end
      end
   endgenerate

   // reset pin edge and blank-vector decode
   assign rst_rise  = pin_ff[PIN_RST] & ~rst_prev_ff;
   assign vec_blank = (vector_high_byte_in == ERASED_BYTE) &&
                      (vector_low_byte_in == ERASED_BYTE);
   assign bit_len   = div_hi_ff ? BAUD_DIV_HI : BAUD_DIV_LO;

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
         rst_prev_ff <= 1'b0;
      else
         rst_prev_ff <= pin_ff[PIN_RST];
   end

   // mode latch: everything sampled on the one rising edge of the reset pin
   // a blank-vector session survives the reset pin; only power-on clears it
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         monitor_ff <= 1'b0;
         blank_ff   <= 1'b0;
         div_hi_ff  <= 1'b1;
      end
      else if (rst_rise && !blank_ff)
      begin
         monitor_ff <= pin_ff[PIN_HV_IRQ] | (vec_blank &
                       pin_ff[PIN_IRQ] & ~pin_ff[PIN_HV_RST]);
         blank_ff   <= ~pin_ff[PIN_HV_IRQ] & vec_blank &
                       pin_ff[PIN_IRQ] & ~pin_ff[PIN_HV_RST];
         // blank entry ignores the divide-select pin and forces /4
         div_hi_ff  <= pin_ff[PIN_DIV] | ~pin_ff[PIN_HV_IRQ];
      end
   end

   // entry sequencer
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || !pin_ff[PIN_RST])
      begin
         state_ff     <= ST_RESET;
         extra_cnt_ff <= '0;
      end
      else
      begin
         unique case (state_ff)
            ST_RESET:
               if (rst_prev_ff)
               begin
                  if (!monitor_ff)
                     state_ff <= ST_USER;
                  else if (blank_ff)
                     state_ff <= ST_EXTRA;
                  else
                     state_ff <= ST_SECURITY;
               end
            ST_EXTRA:
            begin
               extra_cnt_ff <= extra_cnt_ff + 6'h01;
               if (extra_cnt_ff == EXTRA_RST_LAST)
                  state_ff <= ST_SECURITY;
            end
            ST_SECURITY:
               if (sec_cnt_ff == SEC_BYTES)
                  state_ff <= ST_BREAK;
            ST_BREAK:
               if (brk_done_ff)
                  state_ff <= ST_READY;
            ST_READY,
            ST_USER:
               state_ff <= state_ff;
         endcase
      end
   end

   // serial engine: counts security characters, then sends the break;
   // data bits are not kept, checking them is left to the monitor firmware
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || state_ff == ST_RESET)
      begin
         baud_cnt_ff <= '0;
         bit_cnt_ff  <= '0;
         sec_cnt_ff  <= '0;
         rx_busy_ff  <= 1'b0;
         oe_ff       <= 1'b0;
         brk_done_ff <= 1'b0;
      end
      else if (state_ff == ST_SECURITY)
      begin
         if (!rx_busy_ff)
         begin
            if (!pin_ff[PIN_SER])                      // start edge
            begin
               rx_busy_ff  <= 1'b1;
               baud_cnt_ff <= bit_len >> 1;            // sample mid-bit
               bit_cnt_ff  <= START_IDX;
            end
         end
         else if (baud_cnt_ff == '0)
         begin
            baud_cnt_ff <= bit_len - 11'h001;
            if (bit_cnt_ff == START_IDX && pin_ff[PIN_SER])
               rx_busy_ff <= 1'b0;                     // glitch, not a start
            else if (bit_cnt_ff == STOP_IDX)
            begin
               rx_busy_ff <= 1'b0;
               if (pin_ff[PIN_SER])                    // framed char
                  sec_cnt_ff <= sec_cnt_ff + 4'h1;
            end
            else
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
         else
            baud_cnt_ff <= baud_cnt_ff - 11'h001;
      end
      else if (state_ff == ST_BREAK && !brk_done_ff)
      begin
         if (!oe_ff)
         begin
            oe_ff       <= 1'b1;                       // pull low
            baud_cnt_ff <= bit_len - 11'h001;
            bit_cnt_ff  <= START_IDX;
         end
         else if (baud_cnt_ff == '0)
         begin
            baud_cnt_ff <= bit_len - 11'h001;
            if (bit_cnt_ff == BREAK_LAST)
            begin
               oe_ff       <= 1'b0;                    // ten bits done
               brk_done_ff <= 1'b1;
            end
            else
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
         else
            baud_cnt_ff <= baud_cnt_ff - 11'h001;
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         serial_comm_pin_out  <= 1'b0;
         monitor_mode_out     <= 1'b0;
         blank_entry_out      <= 1'b0;
         bus_div4_out         <= 1'b1;
         osc_bypass_out       <= 1'b0;
         baud_div_1024_out    <= 1'b1;
         watchdog_disable_out <= 1'b1;
         vector_page_out      <= USER_PAGE;
         core_reset_out       <= 1'b1;
         ready_out            <= 1'b0;
      end
      else
      begin
         serial_comm_pin_out  <= 1'b0;                 // only ever low
         monitor_mode_out     <= monitor_ff;
         blank_entry_out      <= blank_ff;
         bus_div4_out         <= div_hi_ff;
         osc_bypass_out       <= monitor_ff & ~blank_ff &
                                 ~div_hi_ff;
         baud_div_1024_out    <= div_hi_ff;
         // reset pin low also holds the watchdog off
         watchdog_disable_out <= ~pin_ff[PIN_RST] | blank_ff |
                                 (monitor_ff & (pin_ff[PIN_HV_IRQ] |
                                  pin_ff[PIN_HV_RST]));
         vector_page_out      <= monitor_ff ? MON_PAGE : USER_PAGE;
         core_reset_out       <= (state_ff == ST_RESET) ||
                                 (state_ff == ST_EXTRA);
         ready_out            <= (state_ff == ST_READY);
      end
   end
   assign serial_comm_pin_oe_out = oe_ff;

   // break length helper for checking only
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
         brk_len_ff <= '0;
      else
         brk_len_ff <= oe_ff ? brk_len_ff + 14'h0001 : '0;
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   a_mode_latched: assert property
      (!rst_rise |=> $stable(monitor_ff))
      else $error("monitor mode changed away from reset edge");
   a_blank_persist: assert property (blank_ff |=> blank_ff)
      else $error("blank-vector monitor mode left without power-on");
   a_blank_div: assert property (blank_ff |-> div_hi_ff)
      else $error("blank entry did not force divide by four");
   a_bypass_mode: assert property
      (osc_bypass_out |-> monitor_mode_out && !blank_entry_out &&
                          !bus_div4_out)
      else $error("oscillator bypass outside high-voltage low-select entry");
   a_wdog_blank: assert property (blank_ff |=> watchdog_disable_out)
      else $error("watchdog enabled in blank-vector session");
   a_wdog_hv: assert property
      (monitor_ff && !blank_ff && pin_ff[PIN_RST] && !pin_ff[PIN_HV_IRQ] &&
       !pin_ff[PIN_HV_RST] |=> !watchdog_disable_out)
      else $error("watchdog kept off after high voltage removed");
   a_vector_page: assert property
      (monitor_ff |=> vector_page_out == MON_PAGE)
      else $error("monitor mode not using monitor vector page");
   a_break_after: assert property
      ($rose(oe_ff) |-> sec_cnt_ff == SEC_BYTES)
      else $error("break sent before eight security bytes");
   a_break_len: assert property
      ($fell(oe_ff) |-> brk_len_ff == (div_hi_ff ? BRK_CYC_HI : BRK_CYC_LO))
      else $error("break not ten bit times long");
   a_pin_low: assert property (serial_comm_pin_out == 1'b0)
      else $error("serial pin driven high");
   a_extra_reset: assert property
      (state_ff == ST_EXTRA |=> core_reset_out)
      else $error("extra reset cycle not shown");

   c_blank_entry: cover property ($rose(blank_ff));
   c_hv_entry: cover property ($rose(monitor_ff) && !blank_ff);
   c_break_done: cover property ($fell(oe_ff));
   c_ready: cover property ($rose(ready_out));
endmodule
`default_nettype wire

/* logic/mme_pkg.sv */
`default_nettype none
package mme_pkg;
   // clock and timing
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          EXTRA_RST_NS   = 128;
   // least time: round up to whole cycles
   localparam int          EXTRA_RST_CYC  =
      (EXTRA_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0]  EXTRA_RST_LAST = 6'(EXTRA_RST_CYC - 1);
   // memory values and vector pages
   localparam logic [7:0]  ERASED_BYTE    = 8'hff;
   localparam logic [7:0]  USER_PAGE      = 8'hff;
   localparam logic [7:0]  MON_PAGE       = 8'hfe;
   // serial framing
   localparam logic [3:0]  SEC_BYTES      = 4'h8;
   localparam logic [3:0]  START_IDX      = 4'h0;
   localparam logic [3:0]  STOP_IDX       = 4'h9;
   localparam logic [3:0]  BREAK_LAST     = 4'h9;
   localparam logic [10:0] BAUD_DIV_HI    = 11'h400;
   localparam logic [10:0] BAUD_DIV_LO    = 11'h200;
   localparam logic [13:0] BRK_CYC_HI     = 14'h2800;
   localparam logic [13:0] BRK_CYC_LO     = 14'h1400;
   // synchronised pin vector layout
   localparam int          PIN_W          = 6;
   localparam int          PIN_RST        = 0;
   localparam int          PIN_IRQ        = 1;
   localparam int          PIN_HV_IRQ     = 2;
   localparam int          PIN_HV_RST     = 3;
   localparam int          PIN_DIV        = 4;
   localparam int          PIN_SER        = 5;
   localparam logic [5:0]  PIN_RESET_VAL  = 6'h20;
   typedef enum logic [2:0] {
      ST_RESET,
      ST_EXTRA,
      ST_SECURITY,
      ST_BREAK,
      ST_READY,
      ST_USER
   } mme_state_t;
endpackage
`default_nettype wire

/* testbench/mme_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mme_host_model
(
   input  wire logic        ref_clk_in,
   input  wire logic        go_in,
   input  wire logic [10:0] bit_len_in,
   output logic             pull_low_out,
   output logic             done_out
);
   logic [9:0] frame;
   initial
   begin
      pull_low_out = 1'b0;
      done_out = 1'b0;
   end
   // eight back-to-back characters; idle and ones are left to the pull-up
   always @(posedge go_in)
   begin
      for (int b = 0; b < 8; b++)
      begin
         frame = {1'b1, 8'(8'ha5 + b), 1'b0}; // start, lsb first, stop
         for (int i = 0; i < 10; i++)
         begin
            pull_low_out = !frame[i]; // only ever pulls low
            repeat (bit_len_in) @(negedge ref_clk_in);
         end
      end
      done_out = 1'b1;
   end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   miscompares++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import mme_pkg::*;
   logic clk = 1'b0;
   logic resetn_in = 1'b0;
   logic rpin = 1'b0, irq = 1'b1, hv_irq = 1'b0, hv_rst = 1'b0, sel = 1'b0;
   logic [7:0] vec = 8'h00, vec_lo = 8'h00;
   logic line, go = 1'b0, host_low, host_done;
   logic ser_out, ser_oe, mon, blank, div4, byp, b1024, wd, core_rst, rdy;
   logic [7:0] page;
   int compares = 0, miscompares = 0, cyc = 0, rdly, dhv, n;
   // wired-OR line: pull-up unless either side pulls low; the pull-up
   // also keeps the serial pin high at entry
   assign line = !(ser_oe | host_low);
   mme_monitor_entry mme_monitor_entry_inst (.ref_clk_in(clk),
      .resetn_in(resetn_in), .reset_pin_in(rpin),
      .external_interrupt_pin_in(irq), .test_hv_irq_in(hv_irq),
      .test_hv_rst_in(hv_rst), .clock_divide_select_pin_in(sel),
      .vector_high_byte_in(vec), .vector_low_byte_in(vec_lo),
      .serial_comm_pin_in(line), .serial_comm_pin_out(ser_out),
      .serial_comm_pin_oe_out(ser_oe), .monitor_mode_out(mon),
      .blank_entry_out(blank), .bus_div4_out(div4), .osc_bypass_out(byp),
      .baud_div_1024_out(b1024), .watchdog_disable_out(wd),
      .vector_page_out(page), .core_reset_out(core_rst), .ready_out(rdy));
   // host clock matched to a low divide-select at entry
   mme_host_model mme_host_model_inst (.ref_clk_in(clk), .go_in(go),
      .bit_len_in(11'h200), .pull_low_out(host_low),
      .done_out(host_done));
   initial
   begin
      forever #2 clk = !clk;
   end
   // hang guard: whole run needs roughly 50k cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic por();
      resetn_in = 1'b0;
      repeat (5) @(negedge clk);
      resetn_in = 1'b1;
   endtask
   // pins settle with reset pin low, then release it and wait for the core
   task automatic enter(input logic h, i, s, input logic [7:0] v, vl);
      rpin = 1'b0;
      hv_irq = h; // port A levels are taken as kept by the host
      hv_rst = 1'b0;
      irq = i;
      sel = s;
      vec = v;
      vec_lo = vl;
      repeat (8) @(negedge clk);
      rpin = 1'b1;
      rdly = 0;
      while (core_rst !== 1'b0 && rdly < 200)
      begin
         @(negedge clk);
         rdly++;
      end
      `CHK("rstwait", 1'b1, rdly < 200)
      repeat (4) @(negedge clk);
   endtask
   task automatic user_entry();
      por();
      enter(1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
      `CHK("mon", 1'b0, mon)
      `CHK("page", USER_PAGE, page)
      `CHK("wd", 1'b0, wd)
   endtask
   task automatic hv_high_entry();
      enter(1'b1, 1'b1, 1'b1, 8'h00, 8'h00);
      `CHK("mon", 1'b1, mon)
      `CHK("blank", 1'b0, blank)
      `CHK("div4", 1'b1, div4)
      `CHK("byp", 1'b0, byp)
      `CHK("b1024", 1'b1, b1024)
      `CHK("page", MON_PAGE, page)
      hv_rst = 1'b1;
      repeat (10) @(negedge clk);
      hv_irq = 1'b0;
      sel = 1'b0;
      repeat (10) @(negedge clk);
      `CHK("wd", 1'b1, wd)
      `CHK("div4", 1'b1, div4)
      hv_rst = 1'b0;
      repeat (10) @(negedge clk);
      `CHK("wd", 1'b0, wd)
   endtask
   task automatic hv_low_serial();
      enter(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
      dhv = rdly;
      `CHK("div4", 1'b0, div4)
      `CHK("byp", 1'b1, byp)
      `CHK("b1024", 1'b0, b1024)
      `CHK("rdy", 1'b0, rdy)
      go = 1'b1;
      n = 0;
      while (ser_oe !== 1'b1 && n < 60000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK("hostdone", 1'b1, n > 9 * 8 * 512)
      `CHK("brkout", 1'b0, ser_out)
      `CHK("line", 1'b0, line)
      n = 0;
      while (ser_oe === 1'b1 && n < 20000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK("brklen", 10 * 512, n)
      repeat (3) @(negedge clk);
      `CHK("rdy", 1'b1, rdy)
   endtask
   task automatic blank_entry();
      por();
      // only one vector byte erased: not blank, user mode
      enter(1'b0, 1'b1, 1'b0, ERASED_BYTE, 8'h00);
      `CHK("halfblank", 1'b0, mon)
      enter(1'b0, 1'b1, 1'b0, ERASED_BYTE, ERASED_BYTE);
      `CHK("mon", 1'b1, mon)
      `CHK("blank", 1'b1, blank)
      `CHK("div4", 1'b1, div4)
      `CHK("byp", 1'b0, byp)
      `CHK("b1024", 1'b1, b1024)
      `CHK("xtra", 1'b1, rdly >= dhv + EXTRA_RST_CYC)
      irq = 1'b0;
      repeat (10) @(negedge clk);
      `CHK("wd", 1'b1, wd)
      enter(1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
      `CHK("mon", 1'b1, mon)
      `CHK("blank", 1'b1, blank)
      `CHK("wd", 1'b1, wd)
   endtask
   initial
   begin
      @(negedge clk);
      user_entry();
      hv_high_entry();
      hv_low_serial();
      blank_entry();
      print_verdict();
   end
endmodule
`default_nettype wire
